// >>> acs_params.svh
// Purpose: Constants of the common status and control register bank
// Assumes: APB with 32-bit data, core_clk at 40 MHz
// Notes  : Offsets are byte addresses
//
// Summary of operation
// - Platform class code is an 8-bit enum, valid while logic is idle.
// - Indicators read before start carry valid defaults from load onward.
// - Design version is two bytes: major first, minor second.
// - Init flag reads 1 once logic and adapter are ready, else 0.
// - Adapter power-up and init sequence completes before init flag rises.
// - 32-bit indicator holds identification read from the inserted adapter.
// - Match flag is set only when detected identity equals expected identity.
// - Reference clock frequency in hertz reads as unsigned 32 bits.
// - 8-bit quality status reports conditioning errors degrading data.
// - Die temperature reads as a signed 16-bit value.
// - Profile code: 0 wave host, 1 image host, 2 wave gpu, 3 image gpu.
// - Profile 0 enables all data-acquisition resources; others optional.
// - Profile 1 enables all image resources including serial link.
// - Writable run bit starts all acquisition together; clearing stops it.
// - Writable bit selects simulated acquisition data.
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// Register byte offsets
`define ACS_OFS_PLATFORM    12'h000
`define ACS_OFS_VERSION     12'h004
`define ACS_OFS_STATUS      12'h008
`define ACS_OFS_IDENT       12'h00c
`define ACS_OFS_REFCLK      12'h010
`define ACS_OFS_QUALITY     12'h014
`define ACS_OFS_TEMP        12'h018
`define ACS_OFS_PROFILE     12'h01c
`define ACS_OFS_CONTROL     12'h020
`define ACS_OFS_IRQ_STAT    12'h024
`define ACS_OFS_IRQ_MASK    12'h028

// Field positions
`define ACS_BIT_INIT        0
`define ACS_BIT_MATCH       1
`define ACS_BIT_RUN         0
`define ACS_BIT_SIM         1
`define ACS_EV_INIT         0
`define ACS_EV_QUAL         1
`define ACS_EV_MISMATCH     2
`define ACS_EV_W            3

// Reset values
`define ACS_RST_CONTROL     2'h0
`define ACS_RST_MASK        3'h0

// Timing
`define ACS_CLK_HZ          40000000
`define ACS_PWRUP_US        100
`define ACS_PWRUP_CYC       ((`ACS_PWRUP_US * (`ACS_CLK_HZ / 1000000)))
`define ACS_PROBE_CYC       16'h0004

`endif

// >>> acs_pkg.sv
// Purpose: Types of the common status and control register bank
// Assumes: Constants come from acs_params.svh
// Notes  : Types only
package acs_pkg;

    // Platform class codes
    typedef enum logic [7:0] {
        ACS_PLAT_CARD    = 8'h00,
        ACS_PLAT_CHASSIS = 8'h01,
        ACS_PLAT_BOARD   = 8'h02
    } acs_platform_t;

    // Application profiles
    typedef enum logic [7:0] {
        ACS_PROF_WAVE_HOST  = 8'h00,
        ACS_PROF_IMAGE_HOST = 8'h01,
        ACS_PROF_WAVE_GPU   = 8'h02,
        ACS_PROF_IMAGE_GPU  = 8'h03
    } acs_profile_t;

    // Adapter bring-up states
    typedef enum logic [1:0] {
        ACS_ST_PWRUP = 2'b00,
        ACS_ST_PROBE = 2'b01,
        ACS_ST_READY = 2'b10,
        ACS_ST_DONE  = 2'b11
    } acs_state_t;

    // Design version pair
    typedef struct packed {
        logic [7:0] major;
        logic [7:0] minor;
    } acs_version_t;

    // Run, simulation select and resource enables towards the acquisition logic
    typedef struct packed {
        logic run;
        logic sim;
        logic daq_en;
        logic image_en;
        logic serial_en;
    } acs_ctrl_t;

endpackage

// >>> acs_common_regs.sv
// Purpose: Common identification, status and control register bank
// Assumes: APB slave, one clock, synchronous active-high reset
// Notes  : Adapter pins are synchronised before use
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"

module acs_common_regs #(
    parameter logic [7:0]  PLATFORM  = 8'h00,
    parameter logic [7:0]  VER_MAJOR = 8'h01,
    parameter logic [7:0]  VER_MINOR = 8'h00,
    // Arbitrary value, replace with the expected adapter identity
    parameter logic [31:0] EXPECTED_ADAPTER_IDENT = 32'h0000_a5a5,
    parameter logic [31:0] REF_CLK_HZ = 32'h0262_5a00,
    parameter logic [7:0]  PROFILE   = 8'h00,
    parameter int          PWRUP_CYC = `ACS_PWRUP_CYC
) (
    input  wire logic          core_clk,
    input  wire logic          rst,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic [31:0]   adapter_ident_pin,
    input  wire logic          adapter_ready_pin,
    input  wire logic [7:0]    quality_pin,
    input  wire logic [15:0]   temp_pin,
    output logic               adapter_pwr_en,
    output acs_pkg::acs_ctrl_t ctrl,
    output logic [15:0]        sim_sample,
    output logic               irq
);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [31:0] ident_s1;
    logic [31:0] ident_s2;
    logic        rdy_s1;
    logic        rdy_s2;
    logic [7:0]  qual_s1;
    logic [7:0]  qual_s2;
    logic [15:0] temp_s1;
    logic [15:0] temp_s2;

    // Two stages on every pin; first stage feeds only the second
    // Multi-bit pins are taken as quasi-static: identity is fixed, levels move slowly
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ident_s1 <= 32'h0000_0000;
            ident_s2 <= 32'h0000_0000;
            rdy_s1   <= 1'b0;
            rdy_s2   <= 1'b0;
            qual_s1  <= 8'h00;
            qual_s2  <= 8'h00;
            temp_s1  <= 16'h0000;
            temp_s2  <= 16'h0000;
        end
        else
        begin
            ident_s1 <= adapter_ident_pin;
            ident_s2 <= ident_s1;
            rdy_s1   <= adapter_ready_pin;
            rdy_s2   <= rdy_s1;
            qual_s1  <= quality_pin;
            qual_s2  <= qual_s1;
            temp_s1  <= temp_pin;
            temp_s2  <= temp_s1;
        end
    end

    // ************************************************************
    // Adapter bring-up sequence
    // ************************************************************
    acs_pkg::acs_state_t state;
    logic [31:0] wait_cnt;
    logic [31:0] adapter_ident_word;
    logic        init_complete_flag;
    logic        adapter_match_flag;

    // Power, settle, read identity, wait for ready
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            state    <= acs_pkg::ACS_ST_PWRUP;
            wait_cnt <= 32'h0000_0000;
        end
        else
        begin
            unique case (state)
                acs_pkg::ACS_ST_PWRUP:
                begin
                    // Hold off probing until supply has settled
                    if (wait_cnt >= 32'(PWRUP_CYC - 1))
                    begin
                        state    <= acs_pkg::ACS_ST_PROBE;
                        wait_cnt <= 32'h0000_0000;
                    end
                    else
                        wait_cnt <= wait_cnt + 32'h0000_0001;
                end
                acs_pkg::ACS_ST_PROBE:
                begin
                    if (wait_cnt[15:0] == `ACS_PROBE_CYC)
                        state <= acs_pkg::ACS_ST_READY;
                    else
                        wait_cnt <= wait_cnt + 32'h0000_0001;
                end
                acs_pkg::ACS_ST_READY:
                begin
                    if (rdy_s2)
                        state <= acs_pkg::ACS_ST_DONE;
                end
                acs_pkg::ACS_ST_DONE:
                begin
                    state <= acs_pkg::ACS_ST_DONE;
                end
            endcase
        end
    end

    // Adapter is powered at all times, reset included; the power-up wait counts from reset release
    assign adapter_pwr_en     = 1'b1;
    assign init_complete_flag = (state == acs_pkg::ACS_ST_DONE);

    // Identity captured once the probe window closes
    always_ff @(posedge core_clk)
    begin
        if (rst)
            adapter_ident_word <= 32'h0000_0000;
        else if (state == acs_pkg::ACS_ST_PROBE && wait_cnt[15:0] == `ACS_PROBE_CYC)
            adapter_ident_word <= ident_s2;
    end

    // Match only after a real identity has been read
    assign adapter_match_flag = (state == acs_pkg::ACS_ST_READY || init_complete_flag)
                                && (adapter_ident_word == EXPECTED_ADAPTER_IDENT);

    // ************************************************************
    // Quality and temperature
    // ************************************************************
    logic [7:0]  acq_quality_status;
    logic [15:0] die_temperature;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            acq_quality_status <= 8'h00;
            die_temperature    <= 16'h0000;
        end
        else
        begin
            acq_quality_status <= qual_s2;
            die_temperature    <= temp_s2;
        end
    end

    // ************************************************************
    // Control register
    // ************************************************************
    logic acquisition_run_control;
    logic simulation_select;
    logic wr_en;
    logic rd_en;

    // Reset image of the control word; each bit is picked out by its field position
    localparam logic [1:0] RST_CTRL = `ACS_RST_CONTROL;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    // Both bits start cleared so nothing runs before software asks
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            acquisition_run_control <= RST_CTRL[`ACS_BIT_RUN];
            simulation_select       <= RST_CTRL[`ACS_BIT_SIM];
        end
        else if (wr_en && paddr == `ACS_OFS_CONTROL)
        begin
            acquisition_run_control <= pwdata[`ACS_BIT_RUN];
            simulation_select       <= pwdata[`ACS_BIT_SIM];
        end
    end

    // Resource enables follow profile; one run bit drives all of them
    always_comb
    begin
        ctrl           = '0;
        ctrl.run       = acquisition_run_control;
        ctrl.sim       = simulation_select;
        ctrl.daq_en    = (PROFILE == acs_pkg::ACS_PROF_WAVE_HOST);
        ctrl.image_en  = (PROFILE == acs_pkg::ACS_PROF_IMAGE_HOST);
        ctrl.serial_en = (PROFILE == acs_pkg::ACS_PROF_IMAGE_HOST);
    end

    // ************************************************************
    // Simulated data
    // ************************************************************
    // Ramp stands in for adapter samples while run and simulation are both set
    always_ff @(posedge core_clk)
    begin
        if (rst)
            sim_sample <= 16'h0000;
        else if (acquisition_run_control && simulation_select)
            sim_sample <= sim_sample + 16'h0001;
        else
            sim_sample <= 16'h0000;
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    logic [`ACS_EV_W-1:0] irq_stat;
    logic [`ACS_EV_W-1:0] irq_mask;
    logic [`ACS_EV_W-1:0] ev;
    logic                 init_d;
    logic [7:0]           qual_d;
    logic                 stat_rd;

    // Event edges: init rise, quality change, mismatch seen
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            init_d <= 1'b0;
            qual_d <= 8'h00;
        end
        else
        begin
            init_d <= init_complete_flag;
            qual_d <= acq_quality_status;
        end
    end

    // Quality event fires on any level change, so a restless input can keep it set
    assign ev[`ACS_EV_INIT]     = init_complete_flag && !init_d;
    assign ev[`ACS_EV_QUAL]     = acq_quality_status != qual_d;
    assign ev[`ACS_EV_MISMATCH] = ev[`ACS_EV_INIT] && !adapter_match_flag;
    assign stat_rd              = rd_en && paddr == `ACS_OFS_IRQ_STAT;

    // Read clears only the bits handed out in this transfer's setup cycle, so an
    // event landing between setup and access is kept; a same-cycle event wins too
    always_ff @(posedge core_clk)
    begin
        if (rst)
            irq_stat <= '0;
        else if (stat_rd)
            irq_stat <= (irq_stat & ~prdata[`ACS_EV_W-1:0]) | ev;
        else
            irq_stat <= irq_stat | ev;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            irq_mask <= `ACS_RST_MASK;
        else if (wr_en && paddr == `ACS_OFS_IRQ_MASK)
            irq_mask <= pwdata[`ACS_EV_W-1:0];
    end

    assign irq = |(irq_stat & irq_mask);

    // ************************************************************
    // APB read path
    // ************************************************************
    logic [31:0] next_prdata;
    logic        hit;

    // Constants are valid from reset, before the bring-up finishes
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        hit         = 1'b1;
        unique case (paddr)
            `ACS_OFS_PLATFORM: next_prdata = {24'h0, PLATFORM};
            `ACS_OFS_VERSION:  next_prdata = {16'h0, VER_MAJOR, VER_MINOR};
            `ACS_OFS_STATUS:   next_prdata = {30'h0, adapter_match_flag,
                                              init_complete_flag};
            `ACS_OFS_IDENT:    next_prdata = adapter_ident_word;
            `ACS_OFS_REFCLK:   next_prdata = REF_CLK_HZ;
            `ACS_OFS_QUALITY:  next_prdata = {24'h0, acq_quality_status};
            `ACS_OFS_TEMP:     next_prdata = {16'h0, die_temperature};
            `ACS_OFS_PROFILE:  next_prdata = {24'h0, PROFILE};
            `ACS_OFS_CONTROL:  next_prdata = {30'h0, simulation_select,
                                              acquisition_run_control};
            `ACS_OFS_IRQ_STAT: next_prdata = {29'h0, irq_stat};
            `ACS_OFS_IRQ_MASK: next_prdata = {29'h0, irq_mask};
            default:           hit = 1'b0;
        endcase
    end

    // Zero wait states; data registered in the setup cycle
    // Loading in setup keeps prdata a flip-flop; it holds until the next read setup
    always_ff @(posedge core_clk)
    begin
        if (rst)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= next_prdata;
    end


    // Every register answers at once, so the access phase never stretches
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_INIT_AFTER_SEQ: assert property (init_complete_flag |-> $past(state) != acs_pkg::ACS_ST_PWRUP)
        else $error("init flag raised during power-up wait");
    AST_INIT_LEVEL: assert property ($rose(init_complete_flag) |-> $past(rdy_s2))
        else $error("init flag rose without adapter ready");
    AST_INIT_STAYS: assert property (init_complete_flag |=> init_complete_flag)
        else $error("init flag dropped");
    AST_MATCH: assert property ($rose(adapter_match_flag) |-> $past(ident_s2) == EXPECTED_ADAPTER_IDENT)
        else $error("match flag rose on a foreign identity");
    AST_IDENT_CAPTURE: assert property ($changed(adapter_ident_word) |-> $past(state) == acs_pkg::ACS_ST_PROBE)
        else $error("identity changed outside probe");
    AST_RUN_WRITE: assert property (wr_en && paddr == `ACS_OFS_CONTROL |=>
                                    ctrl.run == $past(pwdata[`ACS_BIT_RUN]))
        else $error("run bit did not follow write");
    AST_SIM_RAMP: assert property (ctrl.run && ctrl.sim ##1 ctrl.run && ctrl.sim |->
                                   sim_sample == $past(sim_sample) + 16'h0001)
        else $error("ramp did not step");
    AST_PROFILE_RES: assert property (ctrl.serial_en |-> ctrl.image_en && !ctrl.daq_en)
        else $error("serial enabled outside image profile");
    AST_DAQ_RES: assert property (ctrl.daq_en |-> PROFILE == 8'h00)
        else $error("acquisition resources on wrong profile");
    AST_QUAL: assert property (acq_quality_status == $past(qual_s2))
        else $error("quality not tracking input");
    AST_TEMP: assert property (die_temperature == $past(temp_s2))
        else $error("temperature not tracking input");
    AST_RESET_CLR: assert property (@(posedge core_clk) $fell(rst) |-> !ctrl.run && !ctrl.sim)
        else $error("controls not cleared after reset");

    // Bring-up ends only from the wait-for-ready state
    AST_INIT_FROM_READY: assert property ($rose(init_complete_flag) |-> $past(state) == acs_pkg::ACS_ST_READY)
        else $error("init flag rose outside the ready wait");

    // Ramp rests at zero whenever run and simulation are not both set
    AST_SIM_IDLE: assert property (!(ctrl.run && ctrl.sim) |=> sim_sample == 16'h0000)
        else $error("ramp not held at zero");

    // Interrupt status: set wins over the read clear, and a read clears what it returned
    AST_EVENT_STICKY: assert property ((|ev) |=> (irq_stat & $past(ev)) == $past(ev))
        else $error("event not latched in status");
    AST_READ_CLEARS: assert property (stat_rd && ev == '0 |=>
                                      (irq_stat & $past(prdata[`ACS_EV_W-1:0])) == '0)
        else $error("status bits survived their read");

    COV_INIT: cover property ($rose(init_complete_flag));
    COV_MATCH: cover property (init_complete_flag && adapter_match_flag);
    COV_SIM_RUN: cover property ((ctrl.run && ctrl.sim) [*3]);
    COV_MISMATCH: cover property (ev[`ACS_EV_MISMATCH]);
    COV_IRQ: cover property ($rose(irq));

endmodule
`default_nettype wire

// >>> acquisition_common_status_regs_tb.sv
// Purpose: Self-checking bench of the common status and control register bank
// Assumes: APB master driven at the rising edge, PWRUP_CYC shortened to 10
// Notes  : Model state is kept in the bench vector m_stat and compared at each interrupt status check except irq_qual
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"

module acquisition_common_status_regs_tb;
    localparam int          PWRUP  = 10;
    localparam logic [31:0] EXP_ID = 32'h0000_c3c3; // Arbitrary identity value
    localparam logic [31:0] REFHZ  = 32'h0262_5a00;

    logic               core_clk = 1'b0;
    logic               rst = 1'b1;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [11:0]        paddr = 12'h000;
    logic [31:0]        pwdata = 32'h0;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [31:0]        ident = EXP_ID;
    logic               ready_pin = 1'b0;
    logic [7:0]         quality = 8'h00;
    logic [15:0]        temp = 16'h0000;
    logic               pwr_en;
    acs_pkg::acs_ctrl_t ctrl_a;
    acs_pkg::acs_ctrl_t ctrl_b;
    logic [15:0]        sim_sample;
    logic               irq;
    int                 n_errors = 0;
    int                 checks_done = 0;
    int                 cyc = 0;
    int                 t_rel;
    logic [31:0]        rd;
    logic               er;
    logic [15:0]        s0;
    logic [7:0]         q_new;
    logic [31:0]        m_stat;

    // ****************************************
    // Clock, cycle count and watchdog
    // ****************************************
    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) cyc <= cyc + 1;

    // Bounded well above the few hundred cycles the tests take
    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        summarize();
    end

    // ****************************************
    // Devices under test
    // ****************************************
    acs_common_regs #(.PLATFORM(8'h01), .VER_MAJOR(8'h03), .VER_MINOR(8'h07), .EXPECTED_ADAPTER_IDENT(EXP_ID),
        .REF_CLK_HZ(REFHZ), .PROFILE(8'h00), .PWRUP_CYC(PWRUP)) u_acs_common_regs (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .adapter_ident_pin(ident),
        .adapter_ready_pin(ready_pin), .quality_pin(quality), .temp_pin(temp), .adapter_pwr_en(pwr_en),
        .ctrl(ctrl_a), .sim_sample(sim_sample), .irq(irq));

    // Image profile copy on the shared bus, so control writes reach the run and simulation bits of both
    acs_common_regs #(.PROFILE(8'h01), .PWRUP_CYC(PWRUP)) u_acs_common_regs_img (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .adapter_ident_pin(ident),
        .adapter_ready_pin(ready_pin), .quality_pin(quality), .temp_pin(temp), .adapter_pwr_en(),
        .ctrl(ctrl_b), .sim_sample(), .irq());

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            n_errors++;
        end
    endtask

    // One APB transfer; a fresh edge first so no signal is driven twice in one step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
            chk("pready", 32'(pready), 32'h1);
    endtask

    task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, rd, exp);
        chk("pslverr", 32'(er), 32'h0);
    endtask

    // Poll the status word until init shows; returns cycles since reset release
    task automatic wait_init(output int dt);
        int k;
        k = 0;
        do
        begin
            apb(1'b0, `ACS_OFS_STATUS, 32'h0);
            k++;
        end
        while (rd[`ACS_BIT_INIT] !== 1'b1 && k < 200);
        dt = cyc - t_rel;
        chk("init_wait", 32'(rd[`ACS_BIT_INIT]), 32'h1);
    endtask

    task automatic do_reset(input int n);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (n) @(posedge core_clk);
        rst <= 1'b0;
        t_rel = cyc;
        m_stat = 32'h0;
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin : main
        int dt;
        void'($urandom(32'h0d26));
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_rel = cyc;
        m_stat = 32'h0;

        // Indicators valid before the logic runs, controls cleared
        rdchk("platform", `ACS_OFS_PLATFORM, 32'h0000_0001);
        rdchk("version", `ACS_OFS_VERSION, 32'h0000_0307);
        rdchk("refclk", `ACS_OFS_REFCLK, REFHZ);
        rdchk("profile", `ACS_OFS_PROFILE, 32'h0000_0000);
        rdchk("control", `ACS_OFS_CONTROL, 32'h0000_0000);
        chk("run_sim", {30'h0, ctrl_a.run, ctrl_a.sim}, 32'h0);
        chk("enables_a", {29'h0, ctrl_a.daq_en, ctrl_a.image_en, ctrl_a.serial_en}, 32'h4);
        chk("enables_b", {29'h0, ctrl_b.daq_en, ctrl_b.image_en, ctrl_b.serial_en}, 32'h3);
        chk("pwr_en", 32'(pwr_en), 32'h1);
        $display("test reset_values done");

        // Adapter not ready: init must still be low after 60 cycles
        repeat (60) @(posedge core_clk);
        rdchk("status_notready", `ACS_OFS_STATUS, 32'h0000_0002);
        ready_pin <= 1'b1;
        wait_init(dt);
        chk("status_ready", rd, 32'h0000_0003);
        rdchk("ident", `ACS_OFS_IDENT, EXP_ID);
        m_stat[`ACS_EV_INIT] = 1'b1;
        rdchk("irq_stat", `ACS_OFS_IRQ_STAT, m_stat);
        m_stat = 32'h0;
        rdchk("irq_cleared", `ACS_OFS_IRQ_STAT, m_stat);
        $display("test bring_up done");

        // Unmasked quality event on the interrupt line, cleared by a status read
        apb(1'b1, `ACS_OFS_IRQ_MASK, 32'h0000_0007);
        @(negedge core_clk);
        chk("irq_idle", 32'(irq), 32'h0);
        @(posedge core_clk);
        quality <= 8'h5a;
        repeat (8) @(negedge core_clk);
        chk("irq_set", 32'(irq), 32'h1);
        rdchk("irq_qual", `ACS_OFS_IRQ_STAT, 32'h0000_0002);
        @(negedge core_clk);
        chk("irq_low", 32'(irq), 32'h0);
        apb(1'b1, `ACS_OFS_IRQ_MASK, 32'h0000_0000);
        $display("test interrupt done");

        // Random quality and temperature levels, model tracks change events
        repeat (6)
        begin
            q_new = 8'($urandom());
            if (q_new !== quality)
                m_stat[`ACS_EV_QUAL] = 1'b1;
            @(posedge core_clk);
            quality <= q_new;
            temp <= 16'($urandom()) | 16'h8000;
            repeat (6) @(posedge core_clk);
            chk("irq_masked", 32'(irq), 32'h0);
            rdchk("quality", `ACS_OFS_QUALITY, {24'h0, quality});
            rdchk("temp", `ACS_OFS_TEMP, {16'h0, temp});
        end
        rdchk("irq_sticky", `ACS_OFS_IRQ_STAT, m_stat);
        $display("test levels done");

        // Run and simulation controls, upper write bits dropped
        apb(1'b1, `ACS_OFS_CONTROL, {30'($urandom()), 2'b11});
        rdchk("control_rw", `ACS_OFS_CONTROL, 32'h0000_0003);
        @(negedge core_clk);
        chk("run_on", {30'h0, ctrl_a.run, ctrl_a.sim}, 32'h3);
        chk("run_on_b", {30'h0, ctrl_b.run, ctrl_b.sim}, 32'h3);
        s0 = sim_sample;
        @(negedge core_clk);
        chk("ramp", 32'(sim_sample), 32'(16'(s0 + 16'h1)));
        apb(1'b1, `ACS_OFS_CONTROL, 32'h0000_0000);
        repeat (2) @(negedge core_clk);
        chk("run_off", {14'h0, sim_sample, ctrl_a.run, ctrl_a.sim}, 32'h0);
        $display("test controls done");

        // Read-only and unmapped places
        apb(1'b1, `ACS_OFS_PLATFORM, $urandom());
        rdchk("platform_ro", `ACS_OFS_PLATFORM, 32'h0000_0001);
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped_data", rd, 32'h0);
        chk("unmapped_err", 32'(er), 32'h1);
        $display("test refusals done");

        // Second reset mid-run with a foreign adapter already ready
        apb(1'b1, `ACS_OFS_CONTROL, 32'h0000_0001);
        ident <= 32'h1234_0000;
        do_reset(2);
        if (quality !== 8'h00)
            m_stat[`ACS_EV_QUAL] = 1'b1;
        rdchk("control_rst", `ACS_OFS_CONTROL, 32'h0000_0000);
        wait_init(dt);
        chk("pwrup_wait", 32'(dt >= PWRUP), 32'h1);
        chk("status_mismatch", rd, 32'h0000_0001);
        rdchk("ident_foreign", `ACS_OFS_IDENT, 32'h1234_0000);
        m_stat[`ACS_EV_INIT] = 1'b1;
        m_stat[`ACS_EV_MISMATCH] = 1'b1;
        rdchk("irq_mismatch", `ACS_OFS_IRQ_STAT, m_stat);
        $display("test mismatch done");
        summarize();
    end
endmodule
`default_nettype wire
